// ### design/interrupt_source_priority_map.sv
// Interrupt source map: peripheral lines onto 32 fixed-priority
// request channels in two 16-channel banks, plus wake-up grouping.
// Assumes all peripheral lines are on clk; wake pins are asynchronous.
//
// Behaviour
// (R1) 32 channels, channel 0 highest, two banks
// (R2) Channel 0: watchdog timeout or terminal count
// (R3) Channels 4-7: timer capture, compare, overflow OR
// (R4) Channels 8, 9: USB high, low priority OR
// (R5) Channel 10: OR of clock generation interrupts
// (R6) Channel 11: MAC and its DMA interrupts
// (R7) Channel 12: OR of eight DMA channels
// (R8) Channel 13: OR of all CAN sources
// (R9) Channel 14: OR of eight motor interrupts
// (R10) Channel 15: converter conversion complete
// (R11) Channels 16-18: OR of five UART interrupts
// (R12) Channels 19, 20: I2C transmit, receive, error
// (R13) Channels 21, 22: all sync serial interrupts
// (R14) Channel 24: RTC alarm, tamper, periodic OR
// (R15) Channel 25: OR of all 32 wake inputs
// (R16) Four wake groups of eight sources each
// (R17) Pins routable to vectored or fast request
// (R18) Channels 26-29 groups, 30 USB resume
// (R19) Channel 31: prefetch and branch cache
// (R20) Request follows its sources, no latching
// (R21) Lowest pending channel reported as highest
`timescale 1ns/1ps
`include "irq_map_cfg.svh"

module interrupt_source_priority_map
    import irq_map_pkg::*;
#(
    parameter int USB_HIGH_W = 4,
    parameter int USB_LOW_W  = 4,
    parameter int CLK_GEN_W  = 4,
    parameter int MAC_W      = 4,
    parameter int MAC_DMA_W  = 2,
    parameter int CAN_W      = 4,
    parameter int SSP_W      = 4,
    parameter int PREFETCH_W = 2
) (
    input  wire logic                            clk,
    input  wire logic                            srst,
    // Watchdog and core
    input  wire logic                            dog_timeout_unit_timeout,
    input  wire logic                            dog_timeout_unit_terminal,
    input  wire logic                            firmware_irq,
    input  wire logic                            debug_rx_irq,
    input  wire logic                            debug_tx_irq,
    // General timers, two capture flags, two compare flags and one overflow flag per timer
    input  wire logic [2*`TIMER_COUNT-1:0]       timer_capture_flag,
    input  wire logic [2*`TIMER_COUNT-1:0]       timer_compare_flag,
    input  wire logic [`TIMER_COUNT-1:0]         timer_overflow_flag,
    // Bank 0 peripherals
    input  wire logic [USB_HIGH_W-1:0]           usb_high_irq,
    input  wire logic [USB_LOW_W-1:0]            usb_low_irq,
    input  wire logic [CLK_GEN_W-1:0]            clock_generation_unit_irq,
    input  wire logic [MAC_W-1:0]                mac_irq,
    input  wire logic [MAC_DMA_W-1:0]            mac_dma_irq,
    input  wire logic [`DMA_CHAN_COUNT-1:0]      dma_chan_irq,
    input  wire logic [CAN_W-1:0]                can_irq,
    input  wire logic [`MOTOR_SRC_W-1:0]         motor_drive_unit_irq,
    input  wire logic                            adc_done,
    // Bank 1 peripherals
    input  wire logic [`UART_COUNT*`UART_SRC_W-1:0] uart_irq,
    input  wire logic [`I2C_COUNT-1:0]           i2c_tx_irq,
    input  wire logic [`I2C_COUNT-1:0]           i2c_rx_irq,
    input  wire logic [`I2C_COUNT-1:0]           i2c_err_irq,
    input  wire logic [`SSP_COUNT*SSP_W-1:0]     sync_serial_port_irq,
    input  wire logic                            supply_droop_detector_warn,
    input  wire logic                            rtc_alarm,
    input  wire logic                            rtc_tamper,
    input  wire logic                            rtc_periodic,
    input  wire logic                            usb_resume,
    input  wire logic [PREFETCH_W-1:0]           prefetch_branch_cache_irq,
    // Wake-up pins, asynchronous
    input  wire logic [5:0]                      port3_wake_pin,
    input  wire logic [7:0]                      port5_wake_pin,
    input  wire logic [7:0]                      port6_wake_pin,
    input  wire logic [7:0]                      port7_wake_pin,
    // Fast route selection, static configuration
    input  wire logic                            fast_pin_enable,
    input  wire logic [`WAKE_SEL_W-1:0]          fast_pin_select,
    // Towards the processor core
    output logic [`CHAN_COUNT-1:0]               vectored_request,
    output logic                                 highest_valid,
    output logic [`CHAN_IDX_W-1:0]               highest_channel,
    output logic                                 bank0_valid,
    output logic [`BANK_IDX_W-1:0]               bank0_channel,
    output logic                                 bank1_valid,
    output logic [`BANK_IDX_W-1:0]               bank1_channel,
    output logic                                 wake_any,
    output logic [`WAKE_GROUP_COUNT-1:0]         wake_group,
    output logic                                 fast_nonvectored_request
);

    // ==========================================================
    // Elaboration checks
    generate
        if (USB_HIGH_W < 1 || USB_LOW_W < 1 || CLK_GEN_W < 1 ||
            MAC_W < 1 || MAC_DMA_W < 1 || CAN_W < 1 || SSP_W < 1 ||
            PREFETCH_W < 1) begin : g_bad_width
            $error("interrupt_source_priority_map: zero source width");
        end
    endgenerate

    // ==========================================================
    // Timer channels
    logic [`TIMER_COUNT-1:0] timer_req;

    genvar t;
    generate
        for (t = 0; t < `TIMER_COUNT; t++) begin : g_timer
            assign timer_req[t] = |timer_capture_flag[2*t +: 2]
                                | |timer_compare_flag[2*t +: 2]
                                | timer_overflow_flag[t]; // (R3)
        end
    endgenerate

    // ==========================================================
    // Serial channels
    logic [`UART_COUNT-1:0] uart_req;
    logic [`I2C_COUNT-1:0]  i2c_req;
    logic [`SSP_COUNT-1:0]  ssp_req;

    genvar u;
    generate
        for (u = 0; u < `UART_COUNT; u++) begin : g_uart
            assign uart_req[u] =
                |uart_irq[u*`UART_SRC_W +: `UART_SRC_W]; // (R11)
        end
        for (u = 0; u < `I2C_COUNT; u++) begin : g_i2c
            assign i2c_req[u] = i2c_tx_irq[u] | i2c_rx_irq[u]
                              | i2c_err_irq[u]; // (R12)
        end
        for (u = 0; u < `SSP_COUNT; u++) begin : g_ssp
            assign ssp_req[u] = |sync_serial_port_irq[u*SSP_W +: SSP_W]; // (R13)
        end
    endgenerate

    // ==========================================================
    // Wake-up grouping
    logic                         rtc_irq;
    logic                         wake_any_c;
    logic [`WAKE_GROUP_COUNT-1:0] wake_group_c;
    logic                         fast_c;

    assign rtc_irq = rtc_alarm | rtc_tamper | rtc_periodic;

    wake_group_unit u_wake (
        .clk             (clk),
        .srst            (srst),
        .wake_pin        ({port7_wake_pin, port6_wake_pin,
                           port5_wake_pin, port3_wake_pin}),
        .rtc_irq         (rtc_irq),
        .usb_resume      (usb_resume),
        .fast_pin_enable (fast_pin_enable),
        .fast_pin_select (fast_pin_select),
        .wake_any        (wake_any_c),
        .wake_group      (wake_group_c),
        .fast_request    (fast_c)
    );

    // ==========================================================
    // Channel assembly
    // Pure ORs of live source levels; nothing is held here, so a
    // request drops as soon as the peripheral clears its own flag.
    logic [`CHAN_COUNT-1:0] req_c;

    always_comb begin
        req_c = '0;
        req_c[`CH_DOG] = dog_timeout_unit_timeout
                       | dog_timeout_unit_terminal; // (R2)
        req_c[`CH_FIRMWARE] = firmware_irq;
        req_c[`CH_DEBUG_RX] = debug_rx_irq;
        req_c[`CH_DEBUG_TX] = debug_tx_irq;
        req_c[`CH_TIMER0 +: `TIMER_COUNT] = timer_req; // (R3)
        req_c[`CH_USB_HIGH] = |usb_high_irq; // (R4)
        req_c[`CH_USB_LOW] = |usb_low_irq; // (R4)
        req_c[`CH_CLOCK_GEN] = |clock_generation_unit_irq; // (R5)
        req_c[`CH_MAC] = |mac_irq | |mac_dma_irq; // (R6)
        req_c[`CH_DMA] = |dma_chan_irq; // (R7)
        req_c[`CH_CAN] = |can_irq; // (R8)
        req_c[`CH_MOTOR] = |motor_drive_unit_irq; // (R9)
        req_c[`CH_ADC] = adc_done; // (R10)
        req_c[`CH_UART0 +: `UART_COUNT] = uart_req; // (R11)
        req_c[`CH_I2C0 +: `I2C_COUNT] = i2c_req; // (R12)
        req_c[`CH_SSP0 +: `SSP_COUNT] = ssp_req; // (R13)
        req_c[`CH_DROOP] = supply_droop_detector_warn;
        req_c[`CH_RTC] = rtc_irq; // (R14)
        req_c[`CH_WAKE_ALL] = wake_any_c; // (R15)
        req_c[`CH_WAKE_GROUP0 +: `WAKE_GROUP_COUNT] = wake_group_c; // (R18)
        req_c[`CH_USB_RESUME] = usb_resume; // (R18)
        req_c[`CH_PREFETCH] = |prefetch_branch_cache_irq; // (R19)
    end

    // ==========================================================
    // Priority resolution
    // Encoders look at the next request so the reported channel
    // lines up with vectored_request in the same cycle.
    logic                   top_valid_c;
    logic [`CHAN_IDX_W-1:0] top_chan_c;
    logic                   b0_valid_c;
    logic [`BANK_IDX_W-1:0] b0_chan_c;
    logic                   b1_valid_c;
    logic [`BANK_IDX_W-1:0] b1_chan_c;

    lowest_pending_encoder #(
        .N   (`CHAN_COUNT),
        .IDX (`CHAN_IDX_W)
    ) u_top_enc (
        .pending (req_c),
        .valid   (top_valid_c),
        .index   (top_chan_c)
    ); // (R21)

    lowest_pending_encoder #(
        .N   (`BANK_SIZE),
        .IDX (`BANK_IDX_W)
    ) u_bank0_enc (
        .pending (req_c[`BANK_SIZE-1:0]),
        .valid   (b0_valid_c),
        .index   (b0_chan_c)
    ); // (R1)

    lowest_pending_encoder #(
        .N   (`BANK_SIZE),
        .IDX (`BANK_IDX_W)
    ) u_bank1_enc (
        .pending (req_c[`CHAN_COUNT-1:`BANK_SIZE]),
        .valid   (b1_valid_c),
        .index   (b1_chan_c)
    ); // (R1)

    // ==========================================================
    // State register
    map_state_t state_q;
    map_state_t state_d;

    always_comb begin
        state_d           = state_q;
        state_d.req       = req_c; // (R20)
        state_d.top_valid = top_valid_c;
        state_d.top_chan  = top_chan_c; // (R21)
        state_d.b0_valid  = b0_valid_c;
        state_d.b0_chan   = b0_chan_c;
        state_d.b1_valid  = b1_valid_c;
        state_d.b1_chan   = b1_chan_c;
        state_d.wake_any  = wake_any_c;
        state_d.wake_grp  = wake_group_c;
        state_d.fast      = fast_c; // (R17)
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state_q           <= '0;
            state_q.req       <= `REQ_RESET;
            state_q.top_chan  <= `CHAN_RESET;
            state_q.b0_chan   <= `BANK_CHAN_RESET;
            state_q.b1_chan   <= `BANK_CHAN_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    // ==========================================================
    // Outputs
    assign vectored_request         = state_q.req;
    assign highest_valid            = state_q.top_valid;
    assign highest_channel          = state_q.top_chan;
    assign bank0_valid              = state_q.b0_valid;
    assign bank0_channel            = state_q.b0_chan;
    assign bank1_valid              = state_q.b1_valid;
    assign bank1_channel            = state_q.b1_chan;
    assign wake_any                 = state_q.wake_any;
    assign wake_group               = state_q.wake_grp;
    assign fast_nonvectored_request = state_q.fast;

endmodule

// ### inc/irq_map_cfg.svh
// Channel numbers, widths and reset values of the interrupt source map.
// Assumes inclusion by the package and the design modules alike.
`ifndef IRQ_MAP_CFG_SVH
`define IRQ_MAP_CFG_SVH

`define CHAN_COUNT       32
`define CHAN_IDX_W       5
`define BANK_SIZE        16
`define BANK_IDX_W       4
`define WAKE_COUNT       32
`define WAKE_PIN_COUNT   30
`define WAKE_GROUP_COUNT 4
`define WAKE_GROUP_SIZE  8
`define WAKE_SEL_W       5
`define TIMER_COUNT      4
`define UART_COUNT       3
`define UART_SRC_W       5
`define I2C_COUNT        2
`define SSP_COUNT        2
`define DMA_CHAN_COUNT   8
`define MOTOR_SRC_W      8

`define CH_DOG           5'h0
`define CH_FIRMWARE      5'h1
`define CH_DEBUG_RX      5'h2
`define CH_DEBUG_TX      5'h3
`define CH_TIMER0        5'h4
`define CH_USB_HIGH      5'h8
`define CH_USB_LOW       5'h9
`define CH_CLOCK_GEN     5'ha
`define CH_MAC           5'hb
`define CH_DMA           5'hc
`define CH_CAN           5'hd
`define CH_MOTOR         5'he
`define CH_ADC           5'hf
`define CH_UART0         5'h10
`define CH_I2C0          5'h13
`define CH_SSP0          5'h15
`define CH_DROOP         5'h17
`define CH_RTC           5'h18
`define CH_WAKE_ALL      5'h19
`define CH_WAKE_GROUP0   5'h1a
`define CH_USB_RESUME    5'h1e
`define CH_PREFETCH      5'h1f

`define WAKE_RTC_BIT     5'h6
`define WAKE_USB_BIT     5'h7

`define REQ_RESET        32'h0000_0000
`define CHAN_RESET       5'h00
`define BANK_CHAN_RESET  4'h0

`endif

// ### inc/irq_map_pkg.sv
// Types shared by the interrupt source map and its wake-up grouping.
// Assumes irq_map_cfg.svh on the include path.
`include "irq_map_cfg.svh"

package irq_map_pkg;

    typedef struct packed {
        logic [`WAKE_PIN_COUNT-1:0] meta;
        logic [`WAKE_PIN_COUNT-1:0] pins;
    } wake_state_t;

    typedef struct packed {
        logic [`CHAN_COUNT-1:0]       req;
        logic                         top_valid;
        logic [`CHAN_IDX_W-1:0]       top_chan;
        logic                         b0_valid;
        logic [`BANK_IDX_W-1:0]       b0_chan;
        logic                         b1_valid;
        logic [`BANK_IDX_W-1:0]       b1_chan;
        logic                         wake_any;
        logic [`WAKE_GROUP_COUNT-1:0] wake_grp;
        logic                         fast;
    } map_state_t;

endpackage

// ### design/lowest_pending_encoder.sv
// Fixed-priority encoder: lowest pending index wins.
// Assumes a combinational caller that registers the result.
`timescale 1ns/1ps

module lowest_pending_encoder #(
    parameter int N   = 32,
    parameter int IDX = 5
) (
    input  wire logic [N-1:0]   pending,
    output logic                valid,
    output logic [IDX-1:0]      index
);

    // ============
    // Elaboration checks
    generate
        if (N < 2 || (1 << IDX) < N) begin : g_bad
            $error("lowest_pending_encoder: index too narrow");
        end
    endgenerate

    // ============
    // Priority chain
    logic [N-1:0] above;
    logic [N-1:0] onehot;

    assign above[0] = 1'b0;
    genvar i;
    genvar b;
    generate
        for (i = 0; i < N; i++) begin : g_chain
            if (i > 0) begin : g_link
                assign above[i] = above[i-1] | pending[i-1];
            end
            assign onehot[i] = pending[i] & ~above[i];
        end
        // Each index bit collects the winners whose number has it set
        for (b = 0; b < IDX; b++) begin : g_bit
            logic [N-1:0] hit;
            for (i = 0; i < N; i++) begin : g_hit
                assign hit[i] = onehot[i] & 1'((i >> b) & 1);
            end
            assign index[b] = |hit;
        end
    endgenerate

    assign valid = |pending;

endmodule

// ### design/wake_group_unit.sv
// Wake-up grouping: pin synchroniser, all-source OR, four group ORs
// and the single-source fast route. Outputs are combinational; the
// caller registers them. Pins arrive from outside the clock domain.
`timescale 1ns/1ps
`include "irq_map_cfg.svh"

module wake_group_unit
    import irq_map_pkg::*;
(
    input  wire logic                         clk,
    input  wire logic                         srst,
    input  wire logic [`WAKE_PIN_COUNT-1:0]   wake_pin,
    input  wire logic                         rtc_irq,
    input  wire logic                         usb_resume,
    input  wire logic                         fast_pin_enable,
    input  wire logic [`WAKE_SEL_W-1:0]       fast_pin_select,
    output logic                              wake_any,
    output logic [`WAKE_GROUP_COUNT-1:0]      wake_group,
    output logic                              fast_request
);

    // ============
    // Two-stage pin synchroniser
    wake_state_t state_q;
    wake_state_t state_d;

    always_comb begin
        state_d      = state_q;
        state_d.meta = wake_pin;
        state_d.pins = state_q.meta;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    // ============
    // Source vector: group 0 holds port 3 pins 0..5, rtc, usb
    logic [`WAKE_COUNT-1:0] src;

    always_comb begin
        src = {state_q.pins[`WAKE_PIN_COUNT-1:6], usb_resume, rtc_irq,
               state_q.pins[5:0]};
    end

    assign wake_any = |src; // (R15)

    genvar g;
    generate
        for (g = 0; g < `WAKE_GROUP_COUNT; g++) begin : g_grp
            assign wake_group[g] =
                |src[g*`WAKE_GROUP_SIZE +: `WAKE_GROUP_SIZE]; // (R16)
        end
    endgenerate

    // One chosen source straight to the fast request
    assign fast_request = fast_pin_enable & src[fast_pin_select]; // (R17)

endmodule

// ### sim/irq_map_checker.sv
// Checker for the interrupt source map: mapping, hold and priority.
// Assumes a bind into the map's top module; one clock domain.
`timescale 1ns/1ps

module irq_map_checker (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        dog_timeout_unit_timeout,
    input  wire logic        dog_timeout_unit_terminal,
    input  wire logic [7:0]  dma_chan_irq,
    input  wire logic [7:0]  motor_drive_unit_irq,
    input  wire logic        adc_done,
    input  wire logic [14:0] uart_irq,
    input  wire logic        usb_resume,
    input  wire logic [31:0] vectored_request,
    input  wire logic        highest_valid,
    input  wire logic [4:0]  highest_channel,
    input  wire logic        bank0_valid,
    input  wire logic [3:0]  bank0_channel,
    input  wire logic        bank1_valid,
    input  wire logic [3:0]  bank1_channel
);
    // ============
    // Source to channel
    default clocking @(posedge clk); endclocking
    default disable iff (srst);

    dog_chan0_a: assert property (
        1'b1 |=> vectored_request[0] ==
            $past(dog_timeout_unit_timeout | dog_timeout_unit_terminal))
        else $error("channel 0 wrong");
    dma_chan12_a: assert property (
        1'b1 |=> vectored_request[12] == $past(|dma_chan_irq))
        else $error("channel 12 wrong");
    motor_chan14_a: assert property (
        $rose(|motor_drive_unit_irq) |=> vectored_request[14])
        else $error("channel 14 missed");
    adc_hold_a: assert property (
        adc_done [*3] |-> vectored_request[15])
        else $error("channel 15 dropped");
    adc_release_a: assert property (
        $fell(adc_done) |=> !vectored_request[15])
        else $error("channel 15 stuck");
    uart_chan18_a: assert property (
        1'b1 |=> vectored_request[18] == $past(|uart_irq[14:10]))
        else $error("channel 18 wrong");
    resume_chans_a: assert property (
        usb_resume |=> &{vectored_request[30], vectored_request[26:25]})
        else $error("resume channels wrong");

    // ============
    // Priority report
    top_lowest_a: assert property (
        highest_valid == (|vectored_request) && (!highest_valid ||
        (vectored_request[highest_channel] && (vectored_request &
        ((32'h1 << highest_channel) - 32'h1)) == 32'h0)))
        else $error("wrong top channel");
    bank0_sel_a: assert property (
        bank0_valid == (|vectored_request[15:0]) &&
        (!bank0_valid || {1'b0, bank0_channel} == highest_channel))
        else $error("bank 0 wrong");
    bank1_sel_a: assert property (
        bank1_valid == (|vectored_request[31:16]) && (!bank1_valid ||
        (vectored_request[5'h10 + {1'b0, bank1_channel}] &&
        (vectored_request[31:16] & ((16'h1 << bank1_channel) - 16'h1))
        == 16'h0)))
        else $error("bank 1 wrong");
endmodule

bind interrupt_source_priority_map irq_map_checker u_chk (.*);

// ### sim/core_request_sink.sv
// Core-side model: takes the top vectored request each cycle.
// Assumes the map's registered priority outputs on the same clock.
`timescale 1ns/1ps

module core_request_sink (
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic       highest_valid,
    input  wire logic [4:0] highest_channel,
    output logic            taken_any,
    output logic [4:0]      taken_channel
);
    // Only the winner is taken; losers stay pending at their source
    always_ff @(posedge clk) begin
        if (srst) begin
            taken_any     <= 1'b0;
            taken_channel <= 5'h00;
        end else begin
            taken_any <= highest_valid;
            if (highest_valid) begin
                taken_channel <= highest_channel;
            end
        end
    end
endmodule

// ### sim/interrupt_source_priority_map_bench.sv
// Bench for the interrupt source map: sweeps, priority, fast route.
// Assumes default source widths; all sources packed in one vector.
`timescale 1ns/1ps

module interrupt_source_priority_map_bench;
    logic         clk;
    logic         srst;
    logic [129:0] s;
    logic         pin_en;
    logic [4:0]   pin_sel;
    logic [31:0]  vectored_request;
    logic         highest_valid;
    logic [4:0]   highest_channel;
    logic         bank0_valid;
    logic [3:0]   bank0_channel;
    logic         bank1_valid;
    logic [3:0]   bank1_channel;
    logic         wake_any;
    logic [3:0]   wake_group;
    logic         fast_nonvectored_request;
    logic         taken_any;
    logic [4:0]   taken_channel;
    int           fails;
    int           checks_done;

    interrupt_source_priority_map u_dut (
        .clk, .srst,
        .dog_timeout_unit_timeout(s[0]), .dog_timeout_unit_terminal(s[1]),
        .firmware_irq(s[2]), .debug_rx_irq(s[3]), .debug_tx_irq(s[4]),
        .timer_capture_flag(s[12:5]), .timer_compare_flag(s[20:13]),
        .timer_overflow_flag(s[24:21]), .usb_high_irq(s[28:25]),
        .usb_low_irq(s[32:29]), .clock_generation_unit_irq(s[36:33]),
        .mac_irq(s[40:37]), .mac_dma_irq(s[42:41]),
        .dma_chan_irq(s[50:43]), .can_irq(s[54:51]),
        .motor_drive_unit_irq(s[62:55]), .adc_done(s[63]),
        .uart_irq(s[78:64]), .i2c_tx_irq(s[80:79]),
        .i2c_rx_irq(s[82:81]), .i2c_err_irq(s[84:83]),
        .sync_serial_port_irq(s[92:85]),
        .supply_droop_detector_warn(s[93]), .rtc_alarm(s[94]),
        .rtc_tamper(s[95]), .rtc_periodic(s[96]), .usb_resume(s[97]),
        .prefetch_branch_cache_irq(s[99:98]),
        .port3_wake_pin(s[105:100]), .port5_wake_pin(s[113:106]),
        .port6_wake_pin(s[121:114]), .port7_wake_pin(s[129:122]),
        .fast_pin_enable(pin_en), .fast_pin_select(pin_sel),
        .vectored_request, .highest_valid, .highest_channel,
        .bank0_valid, .bank0_channel, .bank1_valid, .bank1_channel,
        .wake_any, .wake_group, .fast_nonvectored_request
    );

    core_request_sink u_core (
        .clk, .srst, .highest_valid, .highest_channel,
        .taken_any, .taken_channel
    );

    // ============
    // Expectations
    function automatic logic [31:0] exp_req(input int k);
        int c;
        if (k < 2) c = 0;
        else if (k < 5) c = k - 1;
        else if (k < 21) c = 4 + ((k - 5) % 8) / 2;
        else if (k < 25) c = k - 17;
        else if (k < 41) c = 8 + (k - 25) / 4;
        else if (k < 43) c = 11;
        else if (k < 51) c = 12;
        else if (k < 55) c = 13;
        else if (k < 64) c = (k < 63) ? 14 : 15;
        else if (k < 79) c = 16 + (k - 64) / 5;
        else if (k < 85) c = 19 + (k - 79) % 2;
        else if (k < 94) c = (k < 93) ? 21 + (k - 85) / 4 : 23;
        else if (k < 97) return 32'h0700_0000;
        else if (k < 98) return 32'h4600_0000;
        else if (k < 100) c = 31;
        else if (k < 106) return 32'h0600_0000;
        else return 32'h0200_0000 | (32'h1 << (26 + (k - 98) / 8));
        return 32'h1 << c;
    endfunction

    function automatic logic [5:0] low_of(input logic [31:0] v);
        low_of = 6'h00;
        for (int i = 31; i >= 0; i--) if (v[i]) low_of = {1'b1, 5'(i)};
    endfunction

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic check_out(input logic [31:0] e, input logic f);
        cmp(vectored_request, e);
        cmp(32'({highest_valid, highest_channel}), 32'(low_of(e)));
        cmp(32'({bank0_valid, 1'b0, bank0_channel}),
            32'(low_of({16'h0, e[15:0]})));
        cmp(32'({bank1_valid, 1'b0, bank1_channel}),
            32'(low_of({16'h0, e[31:16]})));
        cmp(32'({wake_any, wake_group, fast_nonvectored_request}),
            32'({e[25], e[29:26], f}));
    endtask

    // ============
    // Scenarios, each entered and left at a falling edge
    task automatic sweep_range(input int lo, input int hi);
        int lat;
        for (int k = lo; k < hi; k++) begin
            // Pins pass a two-flop synchroniser first
            lat = (k < 100) ? 1 : 3;
            s[k] = 1'b1;
            repeat (lat - 1) @(posedge clk);
            #1 check_out(32'h0, 1'b0);
            @(posedge clk);
            #1 check_out(exp_req(k), 1'b0);
            @(negedge clk);
            s[k] = 1'b0;
            repeat (lat - 1) @(posedge clk);
            #1 check_out(exp_req(k), 1'b0);
            @(posedge clk);
            #1 check_out(32'h0, 1'b0);
            @(negedge clk);
        end
    endtask

    task automatic priority_walk();
        s[64:63] = 2'b11;
        s[46] = 1'b1;
        @(posedge clk);
        #1 check_out(32'h0001_9000, 1'b0);
        @(negedge clk);
        s[46] = 1'b0;
        @(posedge clk);
        #1 cmp(32'({taken_any, taken_channel}), 32'h0000_002c);
        repeat (5) @(posedge clk);
        #1 check_out(32'h0001_8000, 1'b0);
        @(negedge clk);
        s[0] = 1'b1;
        s[99] = 1'b1;
        s[64] = 1'b0;
        @(posedge clk);
        #1 check_out(32'h8000_8001, 1'b0);
        @(negedge clk);
        s = '0;
        @(negedge clk);
    endtask

    task automatic fast_route();
        int k;
        for (int sel = 0; sel < 32; sel++) begin
            k = (sel < 6) ? 100 + sel : (sel == 6) ? 94 :
                (sel == 7) ? 97 : 98 + sel;
            pin_en = 1'b1;
            pin_sel = 5'(sel);
            s[k] = 1'b1;
            repeat (3) @(posedge clk);
            #1 check_out(exp_req(k), 1'b1);
            @(negedge clk);
            pin_sel = 5'(sel + 1);
            @(posedge clk);
            #1 cmp(32'(fast_nonvectored_request), 32'h0);
            @(negedge clk);
            pin_en = 1'b0;
            s[k] = 1'b0;
            repeat (3) @(negedge clk);
        end
    endtask

    task automatic mid_reset();
        s[63] = 1'b1;
        s[122] = 1'b1;
        repeat (4) @(negedge clk);
        srst = 1'b1;
        @(posedge clk);
        #1 check_out(32'h0, 1'b0);
        repeat (2) @(negedge clk);
        srst = 1'b0;
        repeat (3) @(posedge clk);
        #1 check_out(32'h2200_8000, 1'b0);
        @(negedge clk);
        s = '0;
        repeat (3) @(negedge clk);
    endtask

    task automatic end_sim();
        $display("checks_done=%0d fails=%0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ============
    // Clock, limit and main sequence
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        end_sim();
    end

    initial begin
        fails = 0;
        checks_done = 0;
        srst = 1'b1;
        s = '0;
        pin_en = 1'b0;
        pin_sel = 5'h00;
        repeat (8) @(posedge clk);
        @(negedge clk);
        srst = 1'b0;
        sweep_range(0, 64);
        sweep_range(64, 130);
        priority_walk();
        fast_route();
        mid_reset();
        end_sim();
    end
endmodule
